// file: common/wapc_map.svh
// Register offsets, field positions, reset values and the averaging shift base of the block.
// Assumes inclusion by bare name from the design modules; the package does not include it.
`ifndef WAPC_MAP_SVH
`define WAPC_MAP_SVH

// Register offsets on the plain register port.
`define WAPC_AMP_CFG 8'h33
`define WAPC_AMP_REF 8'h34
`define WAPC_AMP_AVG 8'h35
`define WAPC_AMP_LAST 8'h36
`define WAPC_PHS_CFG 8'h37
`define WAPC_PHS_REF 8'h38
`define WAPC_PHS_AVG 8'h39
`define WAPC_PHS_LAST 8'h3A
`define WAPC_IRQ_STAT 8'h40
`define WAPC_IRQ_CLR 8'h41
`define WAPC_IRQ_EN 8'h42
`define WAPC_WU_CTRL 8'h43

// Channel indices, also the bit positions in the status, clear, enable and control registers.
`define WAPC_CH_AMP 0
`define WAPC_CH_PHS 1

// Reset values.
`define WAPC_RST8 8'h00
`define WAPC_RST2 2'h0
`define WAPC_RST1 1'b0

// Weight code 00 means 4, a right shift by two; each code step doubles the weight.
`define WAPC_SHIFT_BASE 3'h2

`endif

// file: common/wapc_pkg.sv
// Types shared by the wake-up compare top and its channel module.
// Takes no number from the map header; the weight codes and field widths are set here.
package wapc_pkg;

	// Weight of the newest result in the running average.
	typedef enum logic [1:0] {
		WAPC_W4  = 2'b00,
		WAPC_W8  = 2'b01,
		WAPC_W16 = 2'b10,
		WAPC_W32 = 2'b11
	} wapc_weight_e;

	// Layout of a channel configuration register, most significant field first.
	typedef struct packed {
		logic [3:0]   thr;
		logic         incl;
		wapc_weight_e weight;
		logic         use_avg;
	} wapc_cfg_s;

	// One measurement result as handed over by the measurement path.
	typedef struct packed {
		logic       done;
		logic [7:0] value;
	} wapc_meas_s;

endpackage

// file: hdl/wapc_chan.sv
// One compare channel: last result, running average and threshold check.
// Assumes results arrive as one-cycle pulses on the block clock.
`timescale 1ns/1ps
`include "wapc_map.svh"

module wapc_chan (
	input  wire logic                clk_sys_in,
	input  wire logic                rst_in,
	input  wire wapc_pkg::wapc_cfg_s  cfg_in,
	input  wire logic [7:0]          fixed_ref_in,
	input  wire wapc_pkg::wapc_meas_s meas_in,
	output logic [7:0]               avg_out,
	output logic [7:0]               last_out,
	output logic                     trig_out
);
	logic [7:0] avg_q, avg_d, last_q, last_d, ref_v, diff, sat;
	logic       trig_q, trig_d, exceed;
	logic [2:0] sh;
	logic [9:0] delta, step, sum;

	// Compare against the chosen reference and move the average by a weighted step.
	always_comb
	begin
		ref_v = cfg_in.use_avg ? avg_q : fixed_ref_in;
		diff = (meas_in.value >= ref_v) ? meas_in.value - ref_v : ref_v - meas_in.value;
		exceed = diff > {4'h0, cfg_in.thr};
		sh = `WAPC_SHIFT_BASE + {1'b0, cfg_in.weight};
		delta = {2'b00, meas_in.value} - {2'b00, avg_q};
		step = 10'($signed(delta) >>> sh);
		sum = {2'b00, avg_q} + step;
		// Clamp keeps the average in range even if rounding ever strays.
		sat = sum[9] ? 8'h00 : (sum[8] ? 8'hFF : sum[7:0]);
		avg_d = avg_q;
		last_d = last_q;
		trig_d = 1'b0;
		if (meas_in.done)
		begin
			last_d = meas_in.value;
			trig_d = exceed;
			if (!exceed || cfg_in.incl)
				avg_d = sat;
		end
	end

	// State registers.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			avg_q <= `WAPC_RST8;
			last_q <= `WAPC_RST8;
			trig_q <= `WAPC_RST1;
		end
		else
		begin
			avg_q <= avg_d;
			last_q <= last_d;
			trig_q <= trig_d;
		end
	end

	assign avg_out = avg_q;
	assign last_out = last_q;
	assign trig_out = trig_q;

	a_last_capture: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		meas_in.done |=> last_q == $past(meas_in.value))
		else $error("Last result not captured.");
	a_trig_cause: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		trig_q |-> $past(meas_in.done) && ($past(diff) > {4'h0, $past(cfg_in.thr)}))
		else $error("Trigger without an exceeding result.");
	a_excl_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		meas_in.done && exceed && !cfg_in.incl |=> $stable(avg_q))
		else $error("Excluded result entered the average.");
	a_avg_idle: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		!meas_in.done |=> $stable(avg_q))
		else $error("Average moved without a result.");
endmodule

// file: hdl/wapc_top.sv
// Wake-up amplitude and phase compare: registers, two compare channels, interrupt.
// Assumes timer expiry and measurement results come from logic on the same clock.
//
// Contract
// - Amplitude threshold is upper config nibble
// - Phase threshold is upper config nibble
// - Amplitude bit 3 includes triggering result
// - Phase bit 3 includes triggering result
// - Weight codes select 4, 8, 16, 32
// - Amplitude bit 0 picks fixed or average
// - Phase bit 0 picks fixed or average
// - Reference registers read-write, reset zero
// - Average registers read-only, reset zero
// - Last result registers read-only, reset zero
// - Amplitude measured and checked at expiry
// - Phase measured and checked at expiry
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "wapc_map.svh"

module wapc_top (
	input  wire logic       clk_sys_in,
	input  wire logic       rst_in,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	output logic [7:0]      reg_rdata_out,
	input  wire logic       wake_timeout_in,
	output logic            amp_meas_start_out,
	output logic            phase_meas_start_out,
	input  wire logic       amp_meas_done_in,
	input  wire logic [7:0] amp_meas_value_in,
	input  wire logic       phase_meas_done_in,
	input  wire logic [7:0] phase_meas_value_in,
	output logic            irq_out
);
	// Configuration and reference per channel, index 0 amplitude, 1 phase.
	logic [7:0] cfg_q [2];
	logic [7:0] cfg_d [2];
	logic [7:0] ref_q [2];
	logic [7:0] ref_d [2];

	// Averages, last results and trigger pulses from the channels.
	logic [7:0] avg_v [2];
	logic [7:0] last_v [2];
	logic [1:0] trig_v;

	// Measurement inputs gathered per channel.
	wapc_pkg::wapc_meas_s meas_v [2];

	// Interrupt, control and output state.
	logic [1:0] stat_q;
	logic [1:0] stat_d;
	logic [1:0] en_q;
	logic [1:0] en_d;
	logic [1:0] wuctl_q;
	logic [1:0] wuctl_d;
	logic [1:0] set_v;
	logic [1:0] clr_v;
	logic [1:0] start_q;
	logic [1:0] start_d;
	logic       irq_q;
	logic       irq_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	// Results are handed to the channels as a valid pulse with its value.
	assign meas_v[`WAPC_CH_AMP] = '{done: amp_meas_done_in, value: amp_meas_value_in};
	assign meas_v[`WAPC_CH_PHS] = '{done: phase_meas_done_in, value: phase_meas_value_in};

	// Both channels share one compare structure.
	for (genvar i = 0; i < 2; i++)
	begin : g_ch
		wapc_chan u_chan (
			.clk_sys_in   (clk_sys_in),
			.rst_in       (rst_in),
			.cfg_in       (wapc_pkg::wapc_cfg_s'(cfg_q[i])),
			.fixed_ref_in (ref_q[i]),
			.meas_in      (meas_v[i]),
			.avg_out      (avg_v[i]),
			.last_out     (last_v[i]),
			.trig_out     (trig_v[i])
		);
	end

	// Software writes to the read-write registers; read-only offsets ignore writes.
	always_comb
	begin
		cfg_d = cfg_q;
		ref_d = ref_q;
		en_d = en_q;
		wuctl_d = wuctl_q;
		if (reg_wr_in)
		begin
			case (reg_addr_in)
				`WAPC_AMP_CFG:
					cfg_d[`WAPC_CH_AMP] = reg_wdata_in;
				`WAPC_PHS_CFG:
					cfg_d[`WAPC_CH_PHS] = reg_wdata_in;
				`WAPC_AMP_REF:
					ref_d[`WAPC_CH_AMP] = reg_wdata_in;
				`WAPC_PHS_REF:
					ref_d[`WAPC_CH_PHS] = reg_wdata_in;
				`WAPC_IRQ_EN:
					en_d = reg_wdata_in[1:0];
				`WAPC_WU_CTRL:
					wuctl_d = reg_wdata_in[1:0];
				default:
				begin
				end
			endcase
		end
	end

	// Configuration registers.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cfg_q[`WAPC_CH_AMP] <= `WAPC_RST8;
			cfg_q[`WAPC_CH_PHS] <= `WAPC_RST8;
			ref_q[`WAPC_CH_AMP] <= `WAPC_RST8;
			ref_q[`WAPC_CH_PHS] <= `WAPC_RST8;
			en_q <= `WAPC_RST2;
			wuctl_q <= `WAPC_RST2;
		end
		else
		begin
			cfg_q <= cfg_d;
			ref_q <= ref_d;
			en_q <= en_d;
			wuctl_q <= wuctl_d;
		end
	end

	// Each timer expiry starts a measurement on every enabled channel.
	always_comb
	begin
		start_d[`WAPC_CH_AMP] = wake_timeout_in & wuctl_q[`WAPC_CH_AMP];
		start_d[`WAPC_CH_PHS] = wake_timeout_in & wuctl_q[`WAPC_CH_PHS];
	end

	// Start pulses leave from flip-flops.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			start_q <= `WAPC_RST2;
		else
			start_q <= start_d;
	end

	// Sticky status: a trigger in the cycle of a clear write survives the clear.
	// A trigger on a channel that software has since disabled is dropped, so a
	// late result never raises a wake-up that software no longer asked for.
	always_comb
	begin
		set_v = trig_v & wuctl_q;
		clr_v = (reg_wr_in && reg_addr_in == `WAPC_IRQ_CLR) ? reg_wdata_in[1:0] : `WAPC_RST2;
		stat_d = (stat_q & ~clr_v) | set_v;
		irq_d = |(stat_d & en_d);
	end

	// Interrupt registers.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			stat_q <= `WAPC_RST2;
			irq_q <= `WAPC_RST1;
		end
		else
		begin
			stat_q <= stat_d;
			irq_q <= irq_d;
		end
	end

	// Read data for the cycle after the strobe; unmapped and write-only offsets read zero.
	always_comb
	begin
		rdata_d = `WAPC_RST8;
		if (reg_rd_in)
		begin
			case (reg_addr_in)
				`WAPC_AMP_CFG:
					rdata_d = cfg_q[`WAPC_CH_AMP];
				`WAPC_AMP_REF:
					rdata_d = ref_q[`WAPC_CH_AMP];
				`WAPC_AMP_AVG:
					rdata_d = avg_v[`WAPC_CH_AMP];
				`WAPC_AMP_LAST:
					rdata_d = last_v[`WAPC_CH_AMP];
				`WAPC_PHS_CFG:
					rdata_d = cfg_q[`WAPC_CH_PHS];
				`WAPC_PHS_REF:
					rdata_d = ref_q[`WAPC_CH_PHS];
				`WAPC_PHS_AVG:
					rdata_d = avg_v[`WAPC_CH_PHS];
				`WAPC_PHS_LAST:
					rdata_d = last_v[`WAPC_CH_PHS];
				`WAPC_IRQ_STAT:
					rdata_d = {6'h00, stat_q};
				`WAPC_IRQ_EN:
					rdata_d = {6'h00, en_q};
				`WAPC_WU_CTRL:
					rdata_d = {6'h00, wuctl_q};
				default:
					rdata_d = `WAPC_RST8;
			endcase
		end
	end

	// Read data register; it returns to zero when no read was made.
	always_ff @(posedge clk_sys_in or posedge rst_in)
	begin
		if (rst_in)
			rdata_q <= `WAPC_RST8;
		else
			rdata_q <= rdata_d;
	end

	assign reg_rdata_out = rdata_q;
	assign amp_meas_start_out = start_q[`WAPC_CH_AMP];
	assign phase_meas_start_out = start_q[`WAPC_CH_PHS];
	assign irq_out = irq_q;

	// An enabled expiry is followed by a start pulse one edge later.
	sequence s_amp_expiry;
		wake_timeout_in && wuctl_q[`WAPC_CH_AMP];
	endsequence

	sequence s_phs_expiry;
		wake_timeout_in && wuctl_q[`WAPC_CH_PHS];
	endsequence

	a_amp_start: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		s_amp_expiry |=> amp_meas_start_out ##1 !amp_meas_start_out || $past(wake_timeout_in))
		else $error("Amplitude start pulse wrong.");
	a_phs_start: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		phase_meas_start_out |-> $past(wake_timeout_in) && $past(wuctl_q[`WAPC_CH_PHS]))
		else $error("Phase start without enabled expiry.");
	a_phs_exp: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		s_phs_expiry |=> phase_meas_start_out)
		else $error("Phase start missing.");
	a_amp_irq_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		trig_v[`WAPC_CH_AMP] && wuctl_q[`WAPC_CH_AMP] |=> stat_q[`WAPC_CH_AMP])
		else $error("Amplitude trigger lost despite a clear.");
	a_phs_irq_set: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		trig_v[`WAPC_CH_PHS] && wuctl_q[`WAPC_CH_PHS] |=> stat_q[`WAPC_CH_PHS])
		else $error("Phase trigger lost despite a clear.");
	a_irq_level: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		irq_out == |(stat_q & en_q))
		else $error("Interrupt level disagrees with status.");
	a_avg_read: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		reg_rd_in && reg_addr_in == `WAPC_AMP_AVG |=> reg_rdata_out == $past(avg_v[0]))
		else $error("Average read wrong.");
	a_ref_read: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		reg_wr_in && reg_addr_in == `WAPC_PHS_REF ##1 reg_rd_in && reg_addr_in == `WAPC_PHS_REF
		|=> reg_rdata_out == $past(reg_wdata_in, 2))
		else $error("Reference write and read back differ.");
	a_ro_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		reg_wr_in && reg_addr_in == `WAPC_AMP_LAST && !amp_meas_done_in
		|=> $stable(last_v[0]))
		else $error("Read-only result changed by a write.");
endmodule

// file: tb/test_wakeup_amp_phase_compare.sv
// Self-checking bench for the wake-up amplitude and phase compare block.
// Assumes the register map header and package are compiled before it; no separate model.
`timescale 1ns/1ps

module test_wakeup_amp_phase_compare;
	typedef struct packed {
		logic       wr;
		logic [7:0] a;
		logic [7:0] d;
	} wapc_row_s;

	logic       clk_sys_in;
	logic       rst_in;
	logic       reg_wr;
	logic       reg_rd;
	logic       wake;
	logic       amp_done;
	logic       ph_done;
	logic       amp_start;
	logic       ph_start;
	logic       irq;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [7:0] amp_val;
	logic [7:0] ph_val;
	logic [7:0] avg;
	int         err_count;
	int         checked;

	// Reset reads first, then writes to writable and read-only places, then read-back.
	wapc_row_s rows [27] = '{
		'{1'b0, 8'h33, 8'h00}, '{1'b0, 8'h34, 8'h00}, '{1'b0, 8'h35, 8'h00},
		'{1'b0, 8'h36, 8'h00}, '{1'b0, 8'h37, 8'h00}, '{1'b0, 8'h38, 8'h00},
		'{1'b0, 8'h39, 8'h00}, '{1'b0, 8'h3A, 8'h00}, '{1'b0, 8'h40, 8'h00},
		'{1'b0, 8'h42, 8'h00}, '{1'b0, 8'h43, 8'h00}, '{1'b1, 8'h34, 8'hA5},
		'{1'b1, 8'h38, 8'h5A}, '{1'b1, 8'h35, 8'hFF}, '{1'b1, 8'h3A, 8'hFF},
		'{1'b1, 8'h40, 8'hFF}, '{1'b1, 8'h42, 8'hFF}, '{1'b0, 8'h34, 8'hA5},
		'{1'b0, 8'h38, 8'h5A}, '{1'b0, 8'h35, 8'h00}, '{1'b0, 8'h3A, 8'h00},
		'{1'b0, 8'h40, 8'h00}, '{1'b0, 8'h42, 8'h03}, '{1'b0, 8'h41, 8'h00},
		'{1'b0, 8'h50, 8'h00}, '{1'b1, 8'h36, 8'hFF}, '{1'b0, 8'h36, 8'h00}};

	wapc_top i_dut (
		.clk_sys_in           (clk_sys_in),
		.rst_in               (rst_in),
		.reg_addr_in          (addr),
		.reg_wdata_in         (wdata),
		.reg_wr_in            (reg_wr),
		.reg_rd_in            (reg_rd),
		.reg_rdata_out        (rdata),
		.wake_timeout_in      (wake),
		.amp_meas_start_out   (amp_start),
		.phase_meas_start_out (ph_start),
		.amp_meas_done_in     (amp_done),
		.amp_meas_value_in    (amp_val),
		.phase_meas_done_in   (ph_done),
		.phase_meas_value_in  (ph_val),
		.irq_out              (irq)
	);

	// Free-running 100 MHz clock.
	initial
	begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// A gap cycle follows each strobe so no strobe is assigned twice in one time step.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr <= 1'b0;
		@(posedge clk_sys_in);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys_in);
		reg_rd <= 1'b0;
		#1 check(rdata, exp);
		@(posedge clk_sys_in);
	endtask

	// One result pulse; the interrupt is looked at once the status bit has had time to land.
	task automatic meas(input logic ph, input logic [7:0] v, input logic eirq);
		amp_done <= !ph;
		ph_done <= ph;
		amp_val <= v;
		ph_val <= v;
		@(posedge clk_sys_in);
		amp_done <= 1'b0;
		ph_done <= 1'b0;
		amp_val <= ~v;
		ph_val <= ~v;
		@(posedge clk_sys_in);
		#1 check({7'h00, irq}, {7'h00, eirq});
		@(posedge clk_sys_in);
	endtask

	// Main sequence: table rows, then measurement cases, then a reset in mid-run.
	initial
	begin
		{reg_wr, reg_rd, wake, amp_done, ph_done} = 5'h00;
		{addr, wdata, amp_val, ph_val} = 32'h00000000;
		err_count = 0;
		checked = 0;
		rst_in = 1'b1;
		repeat (16) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(posedge clk_sys_in);
		foreach (rows[i])
			if (rows[i].wr)
				wr(rows[i].a, rows[i].d);
			else
				rd(rows[i].a, rows[i].d);
		// A read right behind a write must already see the new value, then fall back to zero.
		addr <= 8'h38;
		wdata <= 8'h3C;
		reg_wr <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk_sys_in);
		reg_rd <= 1'b0;
		#1 check(rdata, 8'h3C);
		@(posedge clk_sys_in);
		#1 check(rdata, 8'h00);
		@(posedge clk_sys_in);
		wr(8'h33, 8'h40);
		wr(8'h34, 8'h80);
		wr(8'h37, 8'h0F);
		wr(8'h43, 8'h03);
		wr(8'h42, 8'h03);
		wake <= 1'b1;
		@(posedge clk_sys_in);
		wake <= 1'b0;
		#1 check({6'h00, ph_start, amp_start}, 8'h03);
		@(posedge clk_sys_in);
		#1 check({6'h00, ph_start, amp_start}, 8'h00);
		@(posedge clk_sys_in);
		meas(1'b0, 8'h84, 1'b0);
		rd(8'h36, 8'h84);
		rd(8'h35, 8'h21);
		meas(1'b0, 8'h7B, 1'b1);
		rd(8'h40, 8'h01);
		rd(8'h35, 8'h21);
		wr(8'h33, 8'h48);
		meas(1'b0, 8'h7B, 1'b1);
		rd(8'h35, 8'h37);
		wr(8'h41, 8'h01);
		rd(8'h40, 8'h00);
		meas(1'b1, 8'h40, 1'b1);
		rd(8'h40, 8'h02);
		rd(8'h39, 8'h02);
		wr(8'h42, 8'h00);
		#1 check({7'h00, irq}, 8'h00);
		@(posedge clk_sys_in);
		wr(8'h41, 8'h03);
		wr(8'h43, 8'h00);
		meas(1'b1, 8'h00, 1'b0);
		rd(8'h40, 8'h00);
		// Every weight code in turn, each step moving the average up towards full scale.
		avg = 8'h37;
		for (int w = 0; w < 4; w++)
		begin
			wr(8'h33, {4'hF, 1'b1, w[1:0], 1'b0});
			meas(1'b0, 8'hFF, 1'b0);
			avg = avg + ((8'hFF - avg) >> (w + 2));
			rd(8'h35, avg);
		end
		// Only the enabled channel starts; a clear in the cycle of a new trigger must lose.
		wr(8'h43, 8'h01);
		wake <= 1'b1;
		@(posedge clk_sys_in);
		wake <= 1'b0;
		#1 check({6'h00, ph_start, amp_start}, 8'h01);
		@(posedge clk_sys_in);
		amp_done <= 1'b1;
		amp_val <= 8'h00;
		@(posedge clk_sys_in);
		amp_done <= 1'b0;
		addr <= 8'h41;
		wdata <= 8'h01;
		reg_wr <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr <= 1'b0;
		@(posedge clk_sys_in);
		rd(8'h40, 8'h01);
		// A reset in mid-run must return the amplitude registers, the status and the interrupt to zero.
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(posedge clk_sys_in);
		rd(8'h35, 8'h00);
		rd(8'h36, 8'h00);
		rd(8'h33, 8'h00);
		rd(8'h34, 8'h00);
		rd(8'h40, 8'h00);
		#1 check({7'h00, irq}, 8'h00);
		stop_test();
	end

	// Watchdog sized well beyond the roughly 180 cycles the sequence needs.
	initial
	begin
		repeat (5000) @(posedge clk_sys_in);
		err_count++;
		stop_test();
	end
endmodule
